//--- core/ind_pkg.sv
// Constants for the interpolating transmit datapath with carrier oscillator.
// Assumes a serial register port, one 100 MHz clock and a host sample stream.
// Notes on behaviour
// - Third stage offers eight modes decoded exactly as the second stage's.
// - Third stage uses the same short four-tap kernel as the others, trading rejection for area.
// - Oscillator yields cosine and sine of one phase, a quarter turn apart.
// - Mixer multiplies I/Q by carrier and sums products into I and Q.
// - Tuning word is four byte registers at 0x30 through 0x33.
// - Oscillator steps once per first-stage output sample, one or two per input.
// - Any carrier from zero up to the oscillator rate can be programmed.
// - Carrier equals word over two to the 32 times oscillator rate.
// - New word acts only on a 0 to 1 change of bit 0 at 0x36.
// - Mode registers act as soon as written, no strobe needed.
// - Modes live in 0x1C to 0x1E, two and three bit fields, plus bypasses.
// - Premodulation acts only when enabled and first stage is in mode 1 or 3.
// - Four or eight times interpolation yields four or eight output samples.
// - Each stage emits two samples per input, doubling the rate.
// - Two times path gives a wide complex band at any centre.
// - Second plus third stage four times path trades bandwidth for power.
// - First stage modes 0,1 unshifted, 2,3 shifted; odd modes mix I and Q.
// - Later stages modes 0-3 unshifted, 4-7 shifted; only 0 and 4 independent.
// - Premodulation shifts the incoming stream by half its rate.
// - Each stage doubles rate and can be bypassed: ratios one to eight.
package ind_pkg;
  localparam logic [6:0] ADR_MODE_A = 7'h1c;
  localparam logic [6:0] ADR_MODE_B = 7'h1d;
  localparam logic [6:0] ADR_MODE_C = 7'h1e;
  localparam logic [6:0] ADR_FTW_0 = 7'h30;
  localparam logic [6:0] ADR_FTW_1 = 7'h31;
  localparam logic [6:0] ADR_FTW_2 = 7'h32;
  localparam logic [6:0] ADR_FTW_3 = 7'h33;
  localparam logic [6:0] ADR_UPDATE = 7'h36;
  localparam int HB1_BYP_BIT = 2;
  localparam int HB2_BYP_BIT = 3;
  localparam int HB3_BYP_BIT = 4;
  localparam int PREMOD_BIT = 5;
  localparam int UPD_BIT = 0;
  localparam int DATA_PEND_BIT = 7;
  localparam logic [7:0] MODE_A_RST = 8'h00;
  localparam logic [7:0] MODE_B_RST = 8'h00;
  localparam logic [7:0] MODE_C_RST = 8'h00;
  localparam logic [7:0] UPDATE_RST = 8'h00;
  localparam logic [31:0] FTW_RST = 32'h0000_0000;
  localparam logic [4:0] SPI_INSTR_BITS = 5'h08;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam logic [9:0] DIAG_COEF = 10'h0b5;
  localparam logic [16:0][11:0] SINE_TAB = {
    12'h7ff, 12'h7f5, 12'h7d8, 12'h7a7, 12'h763, 12'h70d, 12'h6a6, 12'h62e, 12'h5a7,
    12'h513, 12'h471, 12'h3c5, 12'h30f, 12'h252, 12'h18f, 12'h0c9, 12'h000};
endpackage

//--- core/ind_datapath.sv
// Input FIFO and the interpolating datapath with oscillator and register port.
// Assumes the host stream is synchronous to ref_clk; serial port pins are not.
`timescale 1ns/1ps
`default_nettype none

module ind_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
  } ind_fifo_t;
  ind_fifo_t st_r, st_nxt;
  logic push, pop;

  always_comb begin
    st_nxt = st_r;
    wr_ready = st_r.room;
    rd_valid = (st_r.cnt != '0);
    rd_data = st_r.mem[st_r.rp];
    push = wr_valid & st_r.room;
    pop = rd_valid & rd_ready;
    if (push) begin
      st_nxt.mem[st_r.wp] = wr_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Room kept as a flop so the ready seen by the source is registered
    st_nxt.room = (st_nxt.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.room <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

module ind_datapath #(
  parameter int W = 16,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_i,
  input wire logic [W-1:0] in_q,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_i,
  output logic [W-1:0] out_q
);
  typedef struct packed {
    logic [3:0][W-1:0] hi;
    logic [3:0][W-1:0] hq;
    logic busy;
    logic ph;
    logic [2:0] pre_ph;
    logic [2:0] post_ph;
  } ind_stage_t;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] sdi_s;
    logic [4:0] bit_cnt;
    logic [7:0] sh_in;
    logic rw;
    logic [6:0] addr;
    logic [7:0] sh_out;
    logic sdo;
    logic [7:0] mode_a;
    logic [7:0] mode_b;
    logic [7:0] mode_c;
    logic [7:0] upd;
    logic [31:0] ftw_sh;
    logic [31:0] ftw_act;
    logic pm_ph;
    logic [31:0] phase;
    ind_stage_t [2:0] stg;
    logic out_v;
    logic [W-1:0] out_i;
    logic [W-1:0] out_q;
  } ind_state_t;

  ind_state_t st_r, st_nxt;
  logic f_valid, f_ready;
  logic [2*W-1:0] f_data;
  logic iv [3];
  logic ov [3];
  logic irdy [3];
  logic ordy [3];
  logic bypass [3];
  logic modb [3];
  logic [2:0] cen [3];
  logic [W-1:0] ii [3];
  logic [W-1:0] iq [3];
  logic [W-1:0] oi [3];
  logic [W-1:0] oq [3];
  logic pm_act, f_take;
  logic signed [12:0] mix_c, mix_s;
  logic signed [W+13:0] mi_full, mq_full;
  logic sclk_rise, sclk_fall, cs_act;
  logic [7:0] sh, rd_val;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [2*W-1:0] rot;

  ind_fifo #(.W(2*W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data({in_i, in_q}),
    .rd_valid(f_valid),
    .rd_ready(f_ready),
    .rd_data(f_data)
  );

  // Rotation by p eighth turns; diagonal terms use 181/256 for root two over two
  function automatic logic [2*W-1:0] rot8(input logic [W-1:0] xi, input logic [W-1:0] xq,
                                          input logic [2:0] p);
    logic signed [W:0] a, b;
    logic signed [W+10:0] ta, tb;
    logic [W-1:0] ra, rb;
    a = $signed({xi[W-1], xi}) - $signed({xq[W-1], xq});
    b = $signed({xi[W-1], xi}) + $signed({xq[W-1], xq});
    ta = a * $signed(ind_pkg::DIAG_COEF);
    tb = b * $signed(ind_pkg::DIAG_COEF);
    ra = ta[W+7:8];
    rb = tb[W+7:8];
    case (p)
      3'h0: rot8 = {xi, xq};
      3'h1: rot8 = {ra, rb};
      3'h2: rot8 = {-xq, xi};
      3'h3: rot8 = {-rb, ra};
      3'h4: rot8 = {-xi, -xq};
      3'h5: rot8 = {-ra, -rb};
      3'h6: rot8 = {xq, -xi};
      default: rot8 = {rb, -ra};
    endcase
  endfunction

  // Four-tap half-band odd phase; short kernel keeps area low at the cost of rejection
  function automatic logic [W-1:0] hb_odd(input logic [3:0][W-1:0] h);
    logic signed [W+4:0] e0, e1, e2, e3, s;
    e0 = $signed({{5{h[0][W-1]}}, h[0]});
    e1 = $signed({{5{h[1][W-1]}}, h[1]});
    e2 = $signed({{5{h[2][W-1]}}, h[2]});
    e3 = $signed({{5{h[3][W-1]}}, h[3]});
    s = ((e1 + e2) <<< 3) + (e1 + e2) - e0 - e3;
    hb_odd = s[W+3:4];
  endfunction

  // Quarter-wave table, 64 phase steps per turn
  function automatic logic signed [12:0] sin_q(input logic [5:0] p);
    logic [4:0] idx;
    logic [11:0] m;
    idx = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
    m = ind_pkg::SINE_TAB[idx];
    sin_q = p[5] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

  always_comb begin
    st_nxt = st_r;
    rot = '0;
    // Serial port: first sync flop feeds only the second
    st_nxt.sclk_s = {st_r.sclk_s[1:0], spi_sclk};
    st_nxt.cs_s = {st_r.cs_s[0], spi_cs_n};
    st_nxt.sdi_s = {st_r.sdi_s[0], spi_sdi};
    sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
    sclk_fall = ~st_r.sclk_s[1] & st_r.sclk_s[2];
    cs_act = ~st_r.cs_s[1];
    sh = {st_r.sh_in[6:0], st_r.sdi_s[1]};
    wr_en = 1'b0;
    wr_addr = st_r.addr;
    wr_data = sh;
    case (sh[6:0])
      ind_pkg::ADR_MODE_A: rd_val = st_r.mode_a;
      ind_pkg::ADR_MODE_B: rd_val = st_r.mode_b;
      ind_pkg::ADR_MODE_C: rd_val = st_r.mode_c;
      ind_pkg::ADR_FTW_0: rd_val = st_r.ftw_sh[7:0];
      ind_pkg::ADR_FTW_1: rd_val = st_r.ftw_sh[15:8];
      ind_pkg::ADR_FTW_2: rd_val = st_r.ftw_sh[23:16];
      ind_pkg::ADR_FTW_3: rd_val = st_r.ftw_sh[31:24];
      ind_pkg::ADR_UPDATE: begin
        rd_val = st_r.upd;
        rd_val[ind_pkg::DATA_PEND_BIT] = f_valid;
      end
      default: rd_val = 8'h00;
    endcase
    if (!cs_act) begin
      st_nxt.bit_cnt = 5'h00;
    end else if (sclk_rise && st_r.bit_cnt != ind_pkg::SPI_FRAME_BITS) begin
      st_nxt.sh_in = sh;
      st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
      if (st_r.bit_cnt == ind_pkg::SPI_INSTR_BITS - 5'h01) begin
        st_nxt.rw = sh[7];
        st_nxt.addr = sh[6:0];
        st_nxt.sh_out = rd_val;
      end
      wr_en = (st_r.bit_cnt == ind_pkg::SPI_FRAME_BITS - 5'h01) && !st_r.rw;
    end else if (sclk_fall && st_r.rw && st_r.bit_cnt >= ind_pkg::SPI_INSTR_BITS) begin
      st_nxt.sdo = st_r.sh_out[7];
      st_nxt.sh_out = {st_r.sh_out[6:0], 1'b0};
    end
    if (wr_en) begin
      case (wr_addr)
        ind_pkg::ADR_MODE_A: st_nxt.mode_a = wr_data;
        ind_pkg::ADR_MODE_B: st_nxt.mode_b = wr_data;
        ind_pkg::ADR_MODE_C: st_nxt.mode_c = wr_data;
        ind_pkg::ADR_FTW_0: st_nxt.ftw_sh[7:0] = wr_data;
        ind_pkg::ADR_FTW_1: st_nxt.ftw_sh[15:8] = wr_data;
        ind_pkg::ADR_FTW_2: st_nxt.ftw_sh[23:16] = wr_data;
        ind_pkg::ADR_FTW_3: st_nxt.ftw_sh[31:24] = wr_data;
        ind_pkg::ADR_UPDATE: begin
          st_nxt.upd = wr_data;
          if (wr_data[ind_pkg::UPD_BIT] && !st_r.upd[ind_pkg::UPD_BIT]) begin
            st_nxt.ftw_act = st_r.ftw_sh;
          end
        end
        default: st_nxt.upd = st_r.upd;
      endcase
    end

    // Mode decode in eighth turns of each stage's output rate
    bypass[0] = st_r.mode_a[ind_pkg::HB1_BYP_BIT];
    bypass[1] = st_r.mode_a[ind_pkg::HB2_BYP_BIT];
    bypass[2] = st_r.mode_a[ind_pkg::HB3_BYP_BIT];
    modb[0] = st_r.mode_a[1];
    cen[0] = {1'b0, st_r.mode_a[0], 1'b0};
    modb[1] = st_r.mode_b[2];
    cen[1] = {1'b0, st_r.mode_b[1:0]};
    modb[2] = st_r.mode_c[2];
    cen[2] = {1'b0, st_r.mode_c[1:0]};

    // Premodulation: alternate sign at the input rate
    pm_act = st_r.mode_a[ind_pkg::PREMOD_BIT] & st_r.mode_a[0];
    iv[0] = f_valid;
    ii[0] = st_r.pm_ph && pm_act ? -f_data[2*W-1:W] : f_data[2*W-1:W];
    iq[0] = st_r.pm_ph && pm_act ? -f_data[W-1:0] : f_data[W-1:0];
    mix_c = sin_q(st_r.phase[31:26] + 6'h10);
    mix_s = sin_q(st_r.phase[31:26]);
    mi_full = '0;
    mq_full = '0;
    for (int k = 0; k < 3; k++) begin
      if (bypass[k]) begin
        ov[k] = iv[k];
        oi[k] = ii[k];
        oq[k] = iq[k];
      end else begin
        // Even phase repeats the aligned sample, odd phase interpolates
        rot = rot8(st_r.stg[k].ph ? hb_odd(st_r.stg[k].hi) : st_r.stg[k].hi[2],
                   st_r.stg[k].ph ? hb_odd(st_r.stg[k].hq) : st_r.stg[k].hq[2],
                   st_r.stg[k].post_ph);
        ov[k] = st_r.stg[k].busy;
        oi[k] = rot[2*W-1:W];
        oq[k] = rot[W-1:0];
      end
      if (k == 0) begin
        mi_full = $signed(oi[0]) * mix_c - $signed(oq[0]) * mix_s;
        mq_full = $signed(oi[0]) * mix_s + $signed(oq[0]) * mix_c;
        iv[1] = ov[0];
        ii[1] = mi_full[W+10:11];
        iq[1] = mq_full[W+10:11];
      end else if (k == 1) begin
        iv[2] = ov[1];
        ii[2] = oi[1];
        iq[2] = oq[1];
      end
    end

    ordy[2] = ~st_r.out_v | out_ready;
    for (int k = 2; k >= 0; k--) begin
      irdy[k] = bypass[k] ? ordy[k] : ~st_r.stg[k].busy;
      if (k > 0) begin
        ordy[k-1] = irdy[k];
      end
    end
    f_ready = irdy[0];
    f_take = f_valid & irdy[0];
    if (f_take && pm_act) begin
      st_nxt.pm_ph = ~st_r.pm_ph;
    end
    if (iv[1] && irdy[1]) begin
      st_nxt.phase = st_r.phase + st_r.ftw_act;
    end

    for (int k = 0; k < 3; k++) begin
      if (bypass[k]) begin
        st_nxt.stg[k].busy = 1'b0;
      end else begin
        if (iv[k] && irdy[k]) begin
          rot = rot8(ii[k], iq[k], st_r.stg[k].pre_ph);
          st_nxt.stg[k].hi = {st_r.stg[k].hi[2:0], rot[2*W-1:W]};
          st_nxt.stg[k].hq = {st_r.stg[k].hq[2:0], rot[W-1:0]};
          st_nxt.stg[k].busy = 1'b1;
          st_nxt.stg[k].ph = 1'b0;
          st_nxt.stg[k].pre_ph = st_r.stg[k].pre_ph + {cen[k][1:0], 1'b0};
        end
        if (ov[k] && ordy[k]) begin
          st_nxt.stg[k].ph = 1'b1;
          st_nxt.stg[k].busy = ~st_r.stg[k].ph;
          // Centre shift plus half-rate modulation when the mode asks for it
          st_nxt.stg[k].post_ph = st_r.stg[k].post_ph + cen[k] + {modb[k], 2'b00};
        end
      end
    end
    if (ordy[2]) begin
      st_nxt.out_v = ov[2];
      if (ov[2]) begin
        st_nxt.out_i = oi[2];
        st_nxt.out_q = oq[2];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.sclk_s <= 3'h0;
      st_r.cs_s <= 2'h3;
      st_r.mode_a <= ind_pkg::MODE_A_RST;
      st_r.mode_b <= ind_pkg::MODE_B_RST;
      st_r.mode_c <= ind_pkg::MODE_C_RST;
      st_r.upd <= ind_pkg::UPDATE_RST;
      st_r.ftw_sh <= ind_pkg::FTW_RST;
      st_r.ftw_act <= ind_pkg::FTW_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign spi_sdo = st_r.sdo;
  assign out_valid = st_r.out_v;
  assign out_i = st_r.out_i;
  assign out_q = st_r.out_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_upd_write;
    wr_en && wr_addr == ind_pkg::ADR_UPDATE && wr_data[ind_pkg::UPD_BIT] && !st_r.upd[ind_pkg::UPD_BIT];
  endsequence
  sequence s_take_mid;
    iv[1] && irdy[1] && !bypass[1];
  endsequence

  a_ftw_load: assert property (s_upd_write |=> st_r.ftw_act == $past(st_r.ftw_sh))
    else $error("active word not loaded from shadow");
  a_ftw_hold: assert property (!(wr_en && wr_addr == ind_pkg::ADR_UPDATE && wr_data[ind_pkg::UPD_BIT] && !st_r.upd[ind_pkg::UPD_BIT]) |=> $stable(st_r.ftw_act))
    else $error("active word changed without update rise");
  a_mode_live: assert property (wr_en && wr_addr == ind_pkg::ADR_MODE_B |=> st_r.mode_b == $past(wr_data))
    else $error("mode write not applied at once");
  a_nco_step: assert property (iv[1] && irdy[1] |=> st_r.phase == $past(st_r.phase) + $past(st_r.ftw_act))
    else $error("phase did not advance by word");
  a_nco_idle: assert property (!(iv[1] && irdy[1]) |=> $stable(st_r.phase))
    else $error("phase moved without a sample");
  a_hb_pair: assert property (s_take_mid |=> st_r.stg[1].busy && !st_r.stg[1].ph)
    else $error("stage did not start a sample pair");
  a_byp_through: assert property (bypass[0] |-> ov[0] == iv[0] && oi[0] == ii[0])
    else $error("bypassed stage altered data");
  a_premod_hold: assert property (f_take && !pm_act |=> $stable(st_r.pm_ph))
    else $error("premodulation toggled while off");
endmodule

`default_nettype wire

//--- testbench/ind_host.sv
// Host-side sample source that feeds complex samples into the datapath.
// Assumes ref_clk is shared with the design; requests change 1 ns after an edge.
`timescale 1ns/1ps
`default_nettype none

module ind_host #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [W-1:0] in_i,
  output logic [W-1:0] in_q
);
  int sent;

  initial begin
    in_valid = 1'b0;
    in_i = '0;
    in_q = '0;
    sent = 0;
  end

  // Gap adds idle cycles so a slow host is exercised as well as a prompt one
  task automatic send(input int n, input logic [W-1:0] si, input logic [W-1:0] sq, input int gap);
    for (int k = 0; k < n; k++) begin
      // Valid stays up between back-to-back samples, never dropped and raised at once
      if (k > 0 && gap > 0) begin
        in_valid = 1'b0;
        in_i = ~si;
        in_q = ~sq;
        repeat (gap) @(posedge ref_clk);
        #1;
      end
      in_valid = 1'b1;
      in_i = si;
      in_q = sq;
      do @(posedge ref_clk); while (in_ready !== 1'b1);
      sent++;
      #1;
    end
    in_valid = 1'b0;
    // Idle lines carry junk, never a stale copy of the sample
    in_i = ~si;
    in_q = ~sq;
  endtask
endmodule

`default_nettype wire

//--- testbench/ind_datapath_tb.sv
// Self-checking bench for the interpolating datapath with carrier oscillator.
// Assumes the host model in ind_host and registers reached over the serial port.
`timescale 1ns/1ps
`default_nettype none

module ind_datapath_tb;
  localparam int W = 16;
  localparam int AMP = 4096;
  localparam int TOL = 128;
  localparam logic [W-1:0] AMPV = 16'h1000;
  logic ref_clk, arst_n, spi_sclk, spi_cs_n, spi_sdi, spi_sdo;
  logic in_valid, in_ready, out_valid, stall;
  logic out_ready = 1'b0;
  logic [W-1:0] in_i, in_q, out_i, out_q;
  logic [7:0] rd;
  logic signed [W-1:0] got[$], gq[$];
  int errors, num_checks, s0;
  int cycles = 0;
  // Fields: mode a, mode b, mode c, ratio, kind (0 steady, 1 alternating, 2 half turn per 2)
  logic [31:0] tab[10] = '{32'h1c000010, 32'h18000020, 32'h10000040, 32'h00000080, 32'h04000040,
    32'h1a000021, 32'h38000020, 32'h39000022, 32'h14040021, 32'h0c000421};

  ind_datapath #(.W(W), .FIFO_DEPTH(16)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .in_valid(in_valid), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
    .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i), .out_q(out_q));
  ind_host #(.W(W)) i_host (.ref_clk(ref_clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_i(in_i), .in_q(in_q));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Sink toggles ready so the datapath sees back-pressure on alternate cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got.push_back(out_i);
      gq.push_back(out_q);
    end
    #1;
    out_ready = !stall && !out_ready;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic spi(input logic [7:0] ins, input logic [7:0] wd, output logic [7:0] rv);
    logic [15:0] fr;
    fr = {ins, wd};
    rv = '0;
    spi_cs_n = 1'b0;
    for (int b = 15; b >= 0; b--) begin
      spi_sdi = fr[b];
      repeat (6) @(posedge ref_clk);
      #1;
      if (b < 8) rv = {rv[6:0], spi_sdo};
      spi_sclk = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      spi_sclk = 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    #1;
    spi_cs_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi({1'b0, a}, d, rd);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    spi({1'b1, a}, 8'h00, rd);
    check(32'(rd), 32'(e), "register read");
  endtask

  // Waits for the outputs, then judges the settled second half
  task automatic judge(input int n, input int kind);
    int mn, mx, bad, v, qm;
    logic ok;
    for (int t = 0; t < 4000 && got.size() < n; t++) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
    #1;
    check(32'(got.size()), 32'(n), "output count");
    mn = 32767;
    mx = -32768;
    bad = 0;
    qm = 0;
    for (int k = got.size() / 2; k < got.size(); k++) begin
      v = int'(gq[k]);
      qm = (v > qm) ? v : ((-v > qm) ? -v : qm);
      v = int'(got[k]);
      mn = (v < mn) ? v : mn;
      mx = (v > mx) ? v : mx;
      if (k + 2 < got.size() && (v + int'(got[k+2]) > TOL || v + int'(got[k+2]) < -TOL)) bad++;
    end
    if (kind == 0) ok = (mn >= AMP - TOL) && (mx <= AMP + TOL) && (qm <= TOL);
    else if (kind == 1) ok = (mn <= TOL - AMP) && (mx >= AMP - TOL);
    else ok = (bad == 0) && (mx > AMP / 4);
    check(32'(ok), 32'h1, "waveform shape");
  endtask

  task automatic run(input int n, input int ratio, input int kind, input int gap);
    got.delete();
    gq.delete();
    i_host.send(n, AMPV, '0, gap);
    judge(n * ratio, kind);
  endtask

  task automatic load_word(input logic [7:0] top);
    wr(ind_pkg::ADR_FTW_3, top);
    wr(ind_pkg::ADR_UPDATE, 8'h00);
    wr(ind_pkg::ADR_UPDATE, 8'h01);
  endtask

  initial begin
    arst_n = 1'b0;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    stall = 1'b0;
    errors = 0;
    num_checks = 0;
    repeat (12) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check(32'(out_valid), 32'h0, "output idle after reset");
    check(32'(in_ready), 32'h1, "input ready after reset");
    check(32'(spi_sdo), 32'h0, "serial out low after reset");
    rdchk(ind_pkg::ADR_MODE_A, ind_pkg::MODE_A_RST);
    rdchk(ind_pkg::ADR_MODE_B, ind_pkg::MODE_B_RST);
    rdchk(ind_pkg::ADR_MODE_C, ind_pkg::MODE_C_RST);
    rdchk(ind_pkg::ADR_UPDATE, ind_pkg::UPDATE_RST);
    wr(7'h20, 8'h5a);
    rdchk(7'h20, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ind_pkg::ADR_FTW_0 + 7'(k), 8'(17 * (k + 1)));
      rdchk(ind_pkg::ADR_FTW_0 + 7'(k), 8'(17 * (k + 1)));
    end
    for (int k = 0; k < 3; k++) wr(ind_pkg::ADR_FTW_0 + 7'(k), 8'h00);
    wr(ind_pkg::ADR_FTW_3, 8'h00);
    // Modes act without any strobe; word stays zero throughout
    for (int e = 0; e < 10; e++) begin
      wr(ind_pkg::ADR_MODE_A, tab[e][31:24]);
      wr(ind_pkg::ADR_MODE_B, tab[e][23:16]);
      wr(ind_pkg::ADR_MODE_C, tab[e][15:8]);
      rdchk(ind_pkg::ADR_MODE_A, tab[e][31:24]);
      run(12, int'(tab[e][7:4]), int'(tab[e][3:0]), e % 2);
    end
    // Fill the buffer with the sink stalled, then drain it
    wr(ind_pkg::ADR_MODE_A, 8'h1c);
    stall = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    got.delete();
    gq.delete();
    s0 = i_host.sent;
    fork
      i_host.send(40, AMPV, '0, 0);
    join_none
    for (int t = 0; t < 300 && in_ready !== 1'b0; t++) @(posedge ref_clk);
    #1;
    check(32'(in_ready), 32'h0, "input refused when full");
    spi({1'b1, ind_pkg::ADR_UPDATE}, 8'h00, rd);
    check(32'(rd[7]), 32'h1, "buffer holds data");
    stall = 1'b0;
    judge(40, 0);
    check(32'(i_host.sent - s0), 32'd40, "samples accepted");
    spi({1'b1, ind_pkg::ADR_UPDATE}, 8'h00, rd);
    check(32'(rd[7]), 32'h0, "buffer empty");
    // Quarter-turn word waits for the update rise
    wr(ind_pkg::ADR_FTW_3, 8'h40);
    run(12, 1, 0, 0);
    wr(ind_pkg::ADR_UPDATE, 8'h01);
    run(12, 1, 2, 0);
    wr(ind_pkg::ADR_FTW_3, 8'h00);
    wr(ind_pkg::ADR_UPDATE, 8'h01);
    run(12, 1, 2, 1);
    wr(ind_pkg::ADR_UPDATE, 8'h00);
    wr(ind_pkg::ADR_UPDATE, 8'h01);
    run(12, 1, 0, 0);
    wr(ind_pkg::ADR_MODE_A, 8'h18);
    load_word(8'h40);
    run(12, 2, 2, 0);
    load_word(8'h00);
    complete_run();
  end
endmodule

`default_nettype wire
